//--- hbs_brake_seq.sv
`timescale 1ns/100ps
//
// Operation
// R1: Stop methods 3/4 decelerate under torque cap.
// R2: Reverse torque limit 0-350%, reset 300.
// R3: Applied torque never exceeds motor maximum.
// R4: Host waits 50ms plus release before motion.
// R5: Brake output high releases, low engages.
// R6: Servo off or alarm engages brake.
// R7: Terminal carries brake only when field is 4.
// R8: Standstill servo off drops brake same cycle.
// R9: Servo off wait delays power removal.
// R10: Positive on wait: brake first, power later.
// R11: Negative on wait: power first, brake later.
// R12: Alarm removes motor power at once; code keeps power on through method 3/4 deceleration.
// R13: Running stop begins stop sequence first.
// R14: Engage brake below speed threshold.
// R15: Engage brake when brake wait expires.
// R16: Speed threshold 10-100 rpm, reset 100.
// R17: Brake wait 10-100 x10ms, reset 50.
// R18: Method 3 leaves dynamic brake, 4 coasts.
// R19: Brake wait starts at power removal.
module hbs_brake_seq
	import hbs_pkg::*;
#(
	parameter int unsigned CYC_PER_MS = hbs_pkg::CYCLES_PER_MS
) (
	// Clock and reset.
	input  wire logic                  core_clk_i,
	input  wire logic                  rst_i,
	// Register bus.
	input  wire hbs_pkg::hbs_avm_req_s avm_req_i,
	output logic [31:0]                avm_readdata_o,
	output logic                       avm_waitrequest_o,
	// Drive status.
	input  wire logic                  alarm_i,
	input  wire logic [15:0]           motor_speed_i,
	input  wire logic [8:0]            motor_max_torque_i,
	// Brake, power stage and interrupt.
	output logic [2:0]                 brake_term_o,
	output logic                       motor_power_o,
	output logic                       dyn_brake_o,
	output logic [8:0]                 torque_limit_o,
	output logic                       irq_o
);
	import hbs_pkg::*;

	hbs_state_e               st_q;
	hbs_state_e               st_d;
	logic [31:0]              ctrl_q;
	logic signed [11:0]       son_wait_q;
	logic [8:0]               soff_wait_q;
	logic [6:0]               brk_speed_q;
	logic [6:0]               brk_wait_q;
	logic [8:0]               rev_torque_q;
	logic [IRQ_W-1:0]         irq_stat_q;
	logic [IRQ_W-1:0]         irq_en_q;
	logic                     brake_q;
	logic                     brake_d;
	logic                     pwr_d;
	logic                     db_d;
	logic                     alarm_s;
	logic                     alarm_prev_q;
	logic                     tmr_load;
	logic [12:0]              tmr_ms;
	logic                     tmr_done;
	logic [31:0]              rd_mux;

	// Bus decode: a request is taken when waitrequest is already low.
	wire        req      = avm_req_i.read | avm_req_i.write;
	wire        wr_acc   = avm_req_i.write & ~avm_waitrequest_o;
	wire [7:0]  addr     = avm_req_i.address;
	wire [31:0] wdat     = avm_req_i.writedata;
	wire        wr_ctrl  = wr_acc & (addr == OFS_CTRL);
	wire        wr_son   = wr_acc & (addr == OFS_SON_WAIT);
	wire        wr_soff  = wr_acc & (addr == OFS_SOFF_WAIT);
	wire        wr_bspd  = wr_acc & (addr == OFS_BRK_SPEED);
	wire        wr_bwt   = wr_acc & (addr == OFS_BRK_WAIT);
	wire        wr_rev   = wr_acc & (addr == OFS_REV_TORQUE);
	wire        wr_clr   = wr_acc & (addr == OFS_IRQ_CLR);
	wire        wr_en    = wr_acc & (addr == OFS_IRQ_EN);

	// Out-of-range writes are clamped to the legal span.
	wire signed [31:0] wdat_s  = signed'(wdat);
	wire [11:0]  son_clamp     = (wdat_s > 32'sd2000)  ? SON_WAIT_MAX :
	                             (wdat_s < -32'sd2000) ? SON_WAIT_MIN : wdat[11:0];
	wire [8:0]   soff_clamp    = (wdat > 32'(SOFF_WAIT_MAX)) ? SOFF_WAIT_MAX : wdat[8:0];
	wire [6:0]   brk_clamp     = (wdat < 32'(BRK_RANGE_MIN)) ? BRK_RANGE_MIN :
	                             (wdat > 32'(BRK_RANGE_MAX)) ? BRK_RANGE_MAX : wdat[6:0];
	wire [8:0]   rev_clamp     = (wdat > 32'(REV_TORQUE_MAX)) ? REV_TORQUE_MAX : wdat[8:0];

	// Servo command as seen this cycle, so a clearing write acts at once.
	// Terminal fields follow the same write, so a servo-on shows on the new terminals at once.
	wire [31:0] ctrl_wr  = {12'h000, wdat[19:8], 1'b0, wdat[6:4], 3'h0, wdat[0]};
	wire [31:0] ctrl_nx  = wr_ctrl ? ctrl_wr : ctrl_q;
	wire        son_nx   = ctrl_nx[CTRL_SON_BIT];
	wire [2:0]  stop_sel = ctrl_q[CTRL_STOP_LSB +: 3];
	wire        rev_sel  = (stop_sel == STOP_REV_DB) | (stop_sel == STOP_REV_COAST); // R1 R18
	wire        turning  = (motor_speed_i >= {9'h000, brk_speed_q}); // R16
	wire [12:0] son_abs  = son_wait_q[11] ? 13'(-son_wait_q) : 13'(son_wait_q);
	wire [12:0] soff_ms  = 13'(soff_wait_q * UNIT_10MS);
	wire [12:0] bwt_ms   = 13'(brk_wait_q * UNIT_10MS);
	wire [8:0]  trq_cap  = (rev_torque_q < motor_max_torque_i) ? rev_torque_q : motor_max_torque_i; // R3
	wire        ev_ready = (st_d == ST_RUN) & (st_q != ST_RUN);
	wire        ev_brake = brake_q & ~brake_d;
	wire        ev_alarm = alarm_s & ~alarm_prev_q;
	wire [IRQ_W-1:0] ev_vec = {ev_alarm, ev_brake, ev_ready};

	// Alarm comes from outside the clock domain.
	hbs_sync3 u_alarm_sync (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.async_i    (alarm_i),
		.level_o    (alarm_s)
	);

	// One timer serves the servo-on, servo-off and brake waits.
	hbs_ms_timer #(
		.CYC_PER_MS (CYC_PER_MS)
	) u_timer (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.load_i     (tmr_load),
		.ms_i       (tmr_ms),
		.done_o     (tmr_done)
	);

	// Sequencer: orders brake release against motor power.
	always_comb begin
		st_d     = st_q;
		brake_d  = brake_q;
		pwr_d    = motor_power_o;
		db_d     = dyn_brake_o;
		tmr_load = 1'b0;
		tmr_ms   = '0;
		case (st_q)
			ST_OFF: begin
				brake_d = 1'b0; // R6
				pwr_d   = 1'b0;
				if (son_nx && !alarm_s) begin
					db_d     = 1'b0;
					tmr_load = 1'b1; // R10 R11
					if (son_wait_q > 12'sd0) begin
						brake_d = 1'b1; // R10
						tmr_ms  = son_abs;
						st_d    = ST_ON_PWR;
					end else if (son_wait_q < 12'sd0) begin
						pwr_d  = 1'b1; // R11
						tmr_ms = son_abs;
						st_d   = ST_ON_BRK;
					end else begin
						brake_d = 1'b1;
						pwr_d   = 1'b1;
						st_d    = ST_RUN;
					end
				end
			end
			ST_ON_PWR: begin
				if (!son_nx || alarm_s) begin
					brake_d = 1'b0; // R6
					st_d    = ST_OFF;
				end else if (tmr_done) begin
					pwr_d = 1'b1; // R10
					st_d  = ST_RUN;
				end
			end
			ST_ON_BRK: begin
				if (!son_nx || alarm_s) begin
					pwr_d = 1'b0; // R12
					st_d  = ST_OFF;
				end else if (tmr_done) begin
					brake_d = 1'b1; // R11 R5
					st_d    = ST_RUN;
				end
			end
			ST_RUN: begin
				if (alarm_s) begin
					if (turning && rev_sel) begin
						st_d = ST_DECEL; // R1 R13
					end else begin
						pwr_d = 1'b0; // R12
						if (turning) begin
							tmr_load = 1'b1; // R19
							tmr_ms   = bwt_ms;
							st_d     = ST_COAST; // R13
						end else begin
							brake_d = 1'b0; // R6
							st_d    = ST_OFF;
						end
					end
				end else if (!son_nx) begin
					if (turning) begin
						pwr_d    = 1'b0;
						tmr_load = 1'b1; // R19
						tmr_ms   = bwt_ms;
						st_d     = ST_COAST; // R13
					end else begin
						brake_d  = 1'b0; // R8
						tmr_load = 1'b1;
						tmr_ms   = soff_ms; // R9
						if (soff_wait_q == 9'h000) begin
							pwr_d = 1'b0;
							st_d  = ST_OFF;
						end else begin
							st_d = ST_OFF_DLY;
						end
					end
				end
			end
			ST_OFF_DLY: begin
				if (alarm_s || tmr_done) begin
					pwr_d = 1'b0; // R9 R12
					st_d  = ST_OFF;
				end
			end
			ST_DECEL: begin
				if (!turning) begin
					pwr_d   = 1'b0;
					brake_d = 1'b0;
					db_d    = (stop_sel == STOP_REV_DB); // R18
					st_d    = ST_OFF;
				end
			end
			ST_COAST: begin
				if (!turning || tmr_done) begin
					brake_d = 1'b0; // R14 R15
					st_d    = ST_OFF;
				end
			end
			default: begin
				st_d    = ST_OFF;
				brake_d = 1'b0;
				pwr_d   = 1'b0;
			end
		endcase
	end

	// Sequencer state and power-stage outputs.
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			st_q           <= ST_OFF;
			brake_q        <= 1'b0;
			motor_power_o  <= 1'b0;
			dyn_brake_o    <= 1'b0;
			alarm_prev_q   <= 1'b0;
			torque_limit_o <= '0;
		end else begin
			st_q           <= st_d;
			brake_q        <= brake_d;
			motor_power_o  <= pwr_d;
			dyn_brake_o    <= db_d;
			alarm_prev_q   <= alarm_s;
			torque_limit_o <= (st_d == ST_DECEL) ? trq_cap : motor_max_torque_i; // R1 R3
		end
	end

	// Brake appears only on terminals whose assignment field selects it.
	always_ff @(posedge core_clk_i) begin
		for (int i = 0; i < NUM_TERMS; i++) begin
			if (rst_i) begin
				brake_term_o[i] <= 1'b0;
			end else begin
				brake_term_o[i] <= brake_d & (ctrl_nx[CTRL_TERM_LSB + i*TERM_FIELD_W +: TERM_FIELD_W] == TERM_SEL_BRAKE); // R7
			end
		end
	end

	// Configuration registers; new values apply the next cycle (servo bit and terminal fields in the write cycle), wait values at the next timer load.
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			ctrl_q       <= '0; // R7
			son_wait_q   <= SON_WAIT_RST;
			soff_wait_q  <= SOFF_WAIT_RST;
			brk_speed_q  <= BRK_SPEED_RST; // R16
			brk_wait_q   <= BRK_WAIT_RST; // R17
			rev_torque_q <= REV_TORQUE_RST; // R2
		end else begin
			if (wr_ctrl) ctrl_q <= ctrl_wr;
			if (wr_son) son_wait_q <= son_clamp; // R10
			if (wr_soff) soff_wait_q <= soff_clamp; // R9
			if (wr_bspd) brk_speed_q <= brk_clamp; // R16
			if (wr_bwt) brk_wait_q <= brk_clamp; // R17
			if (wr_rev) rev_torque_q <= rev_clamp; // R2
		end
	end

	// Sticky events: a new event wins over a clear in the same cycle.
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			irq_stat_q <= '0;
			irq_en_q   <= '0;
			irq_o      <= 1'b0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~(wr_clr ? wdat[IRQ_W-1:0] : '0)) | ev_vec;
			if (wr_en) irq_en_q <= wdat[IRQ_W-1:0];
			irq_o      <= |(((irq_stat_q & ~(wr_clr ? wdat[IRQ_W-1:0] : '0)) | ev_vec) & (wr_en ? wdat[IRQ_W-1:0] : irq_en_q));
		end
	end

	// Read data selection.
	always_comb begin
		case (addr)
			OFS_CTRL:       rd_mux = ctrl_q;
			OFS_SON_WAIT:   rd_mux = {{20{son_wait_q[11]}}, son_wait_q};
			OFS_SOFF_WAIT:  rd_mux = {23'h000000, soff_wait_q};
			OFS_BRK_SPEED:  rd_mux = {25'h0000000, brk_speed_q};
			OFS_BRK_WAIT:   rd_mux = {25'h0000000, brk_wait_q};
			OFS_REV_TORQUE: rd_mux = {23'h000000, rev_torque_q};
			OFS_STATUS:     rd_mux = {24'h000000, 1'b0, st_q, alarm_s, dyn_brake_o, motor_power_o, brake_q};
			OFS_IRQ_STAT:   rd_mux = {29'h00000000, irq_stat_q};
			OFS_IRQ_EN:     rd_mux = {29'h00000000, irq_en_q};
			default:        rd_mux = 32'h00000000;
		endcase
	end

	// Every access is answered one cycle after it is raised.
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			avm_waitrequest_o <= 1'b1;
			avm_readdata_o    <= '0;
		end else begin
			avm_waitrequest_o <= ~(req & avm_waitrequest_o);
			if (avm_req_i.read & avm_waitrequest_o) avm_readdata_o <= rd_mux;
		end
	end

	// Checks next to the logic they guard.
	chk_brake_drop_stop: assert property (@(posedge core_clk_i) disable iff (rst_i) // R8
		(st_q == ST_RUN && !alarm_s && wr_ctrl && !wdat[CTRL_SON_BIT] && !turning) |=> (!brake_q && brake_term_o == 3'h0))
		else $error("Brake not engaged in the servo-off cycle at standstill.");
	chk_term_gating: assert property (@(posedge core_clk_i) disable iff (rst_i) // R7
		(brake_term_o != 3'h0) |-> brake_q)
		else $error("Brake terminal active while brake engaged.");
	chk_off_state_safe: assert property (@(posedge core_clk_i) disable iff (rst_i) // R5 R6
		(st_q == ST_OFF && $past(st_q) == ST_OFF) |-> (!brake_q && !motor_power_o))
		else $error("Brake released or power on while servo off.");
	chk_alarm_power_cut: assert property (@(posedge core_clk_i) disable iff (rst_i) // R12
		(st_q == ST_RUN && alarm_s && !(turning && rev_sel)) |=> !motor_power_o)
		else $error("Motor power not removed on alarm.");
	chk_torque_motor_max: assert property (@(posedge core_clk_i) disable iff (rst_i) // R3
		##1 (torque_limit_o <= $past(motor_max_torque_i)))
		else $error("Stopping torque above motor maximum.");
	chk_decel_torque_cap: assert property (@(posedge core_clk_i) disable iff (rst_i) // R1
		(st_q == ST_DECEL && $past(st_q) == ST_DECEL) |-> (torque_limit_o <= $past(rev_torque_q) && motor_power_o))
		else $error("Reverse brake deceleration not capped or unpowered.");
	chk_coast_exit: assert property (@(posedge core_clk_i) disable iff (rst_i) // R14 R15
		(st_q == ST_COAST && (!turning || tmr_done)) |=> (!brake_q && st_q == ST_OFF))
		else $error("Brake not engaged at end of running stop.");
	chk_pos_on_order: assert property (@(posedge core_clk_i) disable iff (rst_i) // R10
		(st_q == ST_ON_PWR) |-> (brake_q && !motor_power_o))
		else $error("Positive servo-on wait order broken.");
	chk_neg_on_order: assert property (@(posedge core_clk_i) disable iff (rst_i) // R11
		(st_q == ST_ON_BRK) |-> (motor_power_o && !brake_q))
		else $error("Negative servo-on wait order broken.");
	chk_param_ranges: assert property (@(posedge core_clk_i) disable iff (rst_i) // R2 R9 R16 R17
		(rev_torque_q <= REV_TORQUE_MAX && soff_wait_q <= SOFF_WAIT_MAX && brk_speed_q >= BRK_RANGE_MIN &&
		 brk_speed_q <= BRK_RANGE_MAX && brk_wait_q >= BRK_RANGE_MIN && brk_wait_q <= BRK_RANGE_MAX))
		else $error("Parameter register outside its legal range.");
	chk_coast_timer_start: assert property (@(posedge core_clk_i) disable iff (rst_i) // R19 R13
		(st_q == ST_RUN && st_d == ST_COAST) |=> (!motor_power_o && brake_q && !tmr_done))
		else $error("Brake wait not started at power removal.");
	chk_db_after_decel: assert property (@(posedge core_clk_i) disable iff (rst_i) // R18
		(st_q == ST_DECEL && !turning) |=> (dyn_brake_o == ($past(stop_sel) == STOP_REV_DB)))
		else $error("State after reverse brake stop is wrong.");
endmodule // hbs_brake_seq

//--- hbs_brake_seq_tb.sv
`timescale 1ns/100ps
module hbs_brake_seq_tb;
	import hbs_pkg::*;
	logic                clk = 1'b0;
	logic                rst = 1'b1;
	hbs_avm_req_s        req = '0;
	logic [31:0]         rdata;
	logic                wreq;
	logic                alarm = 1'b0;
	logic [15:0]         speed;
	logic [8:0]          max_t = 9'd200;
	logic [2:0]          brk;
	logic                pwr;
	logic                dynb;
	logic [8:0]          tlim;
	logic                irq;
	logic                ld = 1'b0;
	logic [15:0]         spd = 16'h0000;
	logic                dec = 1'b0;
	logic                ref_ok;
	int                  n_mismatch = 0;
	int                  num_checks = 0;
	logic [31:0]         v;

	hbs_brake_seq #(.CYC_PER_MS(10)) u_dut (.core_clk_i(clk), .rst_i(rst), .avm_req_i(req),
		.avm_readdata_o(rdata), .avm_waitrequest_o(wreq), .alarm_i(alarm), .motor_speed_i(speed),
		.motor_max_torque_i(max_t), .brake_term_o(brk), .motor_power_o(pwr), .dyn_brake_o(dynb),
		.torque_limit_o(tlim), .irq_o(irq));
	hbs_host_model #(.CYC_PER_MS(10), .REL_MS(5)) u_host (.core_clk_i(clk), .rst_i(rst), .load_i(ld),
		.speed_i(spd), .decay_i(dec), .brake_i(brk[0]), .power_i(pwr), .speed_o(speed), .ref_ok_o(ref_ok));

	// Free-running 125 MHz clock.
	always #4 clk = ~clk;

	// Prints the verdict and ends the run.
	task automatic tally_and_finish();
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Compares a seen value against the expected one.
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	// Bus cycle: holds the request until waitrequest is sampled low.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		req.write <= w;
		req.read <= !w;
		req.address <= a;
		req.writedata <= d;
		do begin
			@(posedge clk);
		end while (wreq !== 1'b0);
		q = rdata;
		req.write <= 1'b0;
		req.read <= 1'b0;
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Control word: servo on, stop method and the three terminal fields.
	function automatic logic [31:0] cw(input logic on, input logic [2:0] m, input logic [11:0] t);
		return {12'h000, t, 1'b0, m, 3'h0, on};
	endfunction

	// Reset values and an unmapped read.
	task automatic t_reset();
		logic [7:0] a[6] = '{OFS_SON_WAIT, OFS_SOFF_WAIT, OFS_BRK_SPEED, OFS_BRK_WAIT, OFS_REV_TORQUE, 8'h3c};
		int e[6] = '{0, 0, 100, 50, 300, 0};
		chk("brake after reset", brk, 3'h0);
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, a[i], 32'h0, v);
			chk("reset value", v, e[i]);
		end
	endtask

	// Out-of-range writes clamp to the field limits, then defaults are restored.
	task automatic t_clamp();
		logic [7:0] a[5] = '{OFS_REV_TORQUE, OFS_BRK_SPEED, OFS_BRK_WAIT, OFS_SOFF_WAIT, OFS_SON_WAIT};
		int w[5] = '{400, 5, 200, 600, 3000};
		int e[5] = '{350, 10, 100, 500, 2000};
		int r[5] = '{300, 100, 50, 0, 0};
		for (int i = 0; i < 5; i++) begin
			wr(a[i], w[i]);
			bus(1'b0, a[i], 32'h0, v);
			chk("clamped value", v[11:0], e[i]);
			wr(a[i], r[i]);
		end
	endtask

	// Each terminal carries the brake only when its field is 4; off at standstill drops it at once.
	task automatic t_terms();
		logic [11:0] tw;
		for (int t = 0; t < 3; t++) begin
			tw = 12'h333;
			tw[t*4 +: 4] = TERM_SEL_BRAKE;
			wr(OFS_CTRL, cw(1'b1, 3'h0, tw));
			chk("brake terminal", brk, 3'h1 << t);
			chk("power on", pwr, 1'b1);
			wr(OFS_CTRL, cw(1'b0, 3'h0, tw));
			chk("brake at off", brk, 3'h0);
			chk("power at off", pwr, 1'b0);
			cyc(5);
		end
	endtask

	// Signed servo-on wait orders brake and power; off wait delays power removal.
	task automatic t_onwait(input logic [31:0] w);
		logic pos;
		pos = !w[31];
		wr(OFS_SON_WAIT, w);
		wr(OFS_SOFF_WAIT, 32'h1);
		wr(OFS_CTRL, cw(1'b1, 3'h0, 12'h444));
		chk("first brake", brk, pos ? 3'h7 : 3'h0);
		chk("first power", pwr, !pos);
		cyc(40);
		chk("still waiting", {brk[0], pwr}, pos ? 2'b10 : 2'b01);
		cyc(20);
		chk("both up", {brk[0], pwr}, 2'b11);
		wr(OFS_CTRL, cw(1'b0, 3'h0, 12'h444));
		chk("brake at off", brk, 3'h0);
		cyc(90);
		chk("power held", pwr, 1'b1);
		cyc(20);
		chk("power dropped", pwr, 1'b0);
		wr(OFS_SOFF_WAIT, 32'h0);
		wr(OFS_SON_WAIT, 32'h0);
	endtask

	// Running stop: power off at once, brake waits for speed or for the brake wait time.
	task automatic t_run(input logic by_speed);
		int n;
		n = 0;
		wr(OFS_BRK_WAIT, by_speed ? 32'd50 : 32'd10);
		wr(OFS_CTRL, cw(1'b1, 3'h0, 12'h444));
		while (!ref_ok && n < 1000) begin
			cyc(1);
			n++;
		end
		@(posedge clk);
		ld <= 1'b1;
		spd <= 16'd500;
		@(posedge clk);
		ld <= 1'b0;
		wr(OFS_CTRL, cw(1'b0, 3'h0, 12'h444));
		chk("power at running off", pwr, 1'b0);
		chk("brake held turning", brk, 3'h7);
		if (by_speed) begin
			@(posedge clk);
			dec <= 1'b1;
			n = 0;
			while (speed !== 16'd101 && n < 1000) begin
				cyc(1);
				n++;
			end
			chk("brake above threshold", brk, 3'h7);
			cyc(5);
			chk("brake below threshold", brk, 3'h0);
		end else begin
			cyc(980);
			chk("brake before wait", brk, 3'h7);
			cyc(40);
			chk("brake after wait", brk, 3'h0);
			@(posedge clk);
			dec <= 1'b1;
		end
		cyc(600);
		@(posedge clk);
		dec <= 1'b0;
		wr(OFS_BRK_WAIT, 32'd50);
	endtask

	// Alarm drops power at once; the interrupt follows enable and clear.
	task automatic t_alarm();
		int n;
		n = 0;
		wr(OFS_IRQ_EN, 32'h4);
		wr(OFS_SOFF_WAIT, 32'h5);
		wr(OFS_CTRL, cw(1'b1, 3'h0, 12'h444));
		@(posedge clk);
		alarm <= 1'b1;
		do begin
			cyc(1);
			n++;
		end while (pwr !== 1'b0 && n < 20);
		chk("alarm power lag ok", n <= 6, 1'b1);
		chk("brake on alarm", brk, 3'h0);
		cyc(2);
		chk("irq raised", irq, 1'b1);
		bus(1'b0, OFS_IRQ_STAT, 32'h0, v);
		chk("alarm status", v[IRQ_ALARM], 1'b1);
		wr(OFS_IRQ_EN, 32'h0);
		cyc(2);
		chk("irq masked", irq, 1'b0);
		wr(OFS_IRQ_EN, 32'h4);
		wr(OFS_CTRL, 32'h0);
		@(posedge clk);
		alarm <= 1'b0;
		wr(OFS_IRQ_CLR, 32'h4);
		cyc(2);
		chk("irq cleared", irq, 1'b0);
		wr(OFS_SOFF_WAIT, 32'h0);
		cyc(10);
	endtask

	// Stop methods 3 and 4: capped deceleration, then dynamic brake or coast.
	task automatic t_rev();
		logic [2:0] m;
		int n;
		for (int i = 0; i < 2; i++) begin
			m = i ? STOP_REV_COAST : STOP_REV_DB;
			n = 0;
			wr(OFS_REV_TORQUE, 32'd50);
			wr(OFS_CTRL, cw(1'b1, m, 12'h444));
			@(posedge clk);
			ld <= 1'b1;
			spd <= 16'd500;
			alarm <= 1'b1;
			@(posedge clk);
			ld <= 1'b0;
			cyc(8);
			chk("capped torque", tlim, 9'd50);
			chk("power in decel", pwr, 1'b1);
			wr(OFS_REV_TORQUE, 32'd300);
			cyc(2);
			chk("torque at motor max", tlim, 9'd200);
			@(posedge clk);
			dec <= 1'b1;
			do begin
				cyc(1);
				n++;
			end while (pwr !== 1'b0 && n < 1000);
			chk("brake after decel", brk, 3'h0);
			chk("dynamic brake", dynb, !i);
			@(posedge clk);
			alarm <= 1'b0;
			dec <= 1'b0;
			wr(OFS_CTRL, 32'h0);
			cyc(10);
		end
	endtask

	// Cuts a hung run short.
	initial begin
		#(8 * 60000);
		n_mismatch++;
		tally_and_finish();
	end

	// Main sequence.
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		cyc(2);
		t_reset();
		t_clamp();
		t_terms();
		t_onwait(32'd5);
		t_onwait(32'hffff_fffb);
		t_run(1'b1);
		t_run(1'b0);
		t_alarm();
		t_rev();
		tally_and_finish();
	end
endmodule // hbs_brake_seq_tb

//--- hbs_host_model.sv
`timescale 1ns/100ps
// Far-side model: motor speed plant and the host's reference gate after servo on.
module hbs_host_model #(
	parameter int unsigned CYC_PER_MS = 10,
	parameter int unsigned REL_MS     = 5
) (
	// Clock and reset.
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	// Bench control of the plant.
	input  wire logic        load_i,
	input  wire logic [15:0] speed_i,
	input  wire logic        decay_i,
	// Drive side.
	input  wire logic        brake_i,
	input  wire logic        power_i,
	output logic [15:0]      speed_o,
	output logic             ref_ok_o
);
	int unsigned cnt_q;

	// Speed holds what was loaded and, when told to, falls one rpm per cycle.
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			speed_o <= 16'h0000;
		end else if (load_i) begin
			speed_o <= speed_i;
		end else if (decay_i && speed_o != 16'h0000) begin
			speed_o <= speed_o - 16'h0001;
		end
	end

	// The host counts from brake release with power up before it may send references.
	always_ff @(posedge core_clk_i) begin
		if (rst_i || !(brake_i && power_i)) begin
			cnt_q <= 0;
		end else if (!ref_ok_o) begin
			cnt_q <= cnt_q + 1;
		end
	end
	assign ref_ok_o = cnt_q >= (50 + REL_MS) * CYC_PER_MS;
endmodule // hbs_host_model

//--- hbs_ms_timer.sv
`timescale 1ns/100ps
module hbs_ms_timer #(
	parameter int unsigned CYC_PER_MS = 125000
) (
	// Clock and reset.
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	// Load a count in milliseconds; done stays high once it has run out.
	input  wire logic        load_i,
	input  wire logic [12:0] ms_i,
	output logic             done_o
);
	logic [16:0] pre_q;
	logic [12:0] cnt_q;
	wire         tick = (pre_q == 17'(CYC_PER_MS - 1));

	// Prescaler restarts on each load so a wait is never shortened.
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			pre_q  <= '0;
			cnt_q  <= '0;
			done_o <= 1'b1;
		end else if (load_i) begin
			pre_q  <= '0;
			cnt_q  <= ms_i;
			done_o <= (ms_i == 13'h0000);
		end else if (!done_o) begin
			pre_q <= tick ? 17'h00000 : pre_q + 17'h00001;
			if (tick) begin
				cnt_q  <= cnt_q - 13'h0001;
				done_o <= (cnt_q == 13'h0001);
			end
		end
	end
endmodule // hbs_ms_timer

//--- hbs_pkg.sv
package hbs_pkg;

	// Clock and timebase.
	localparam int unsigned CLK_HZ         = 125_000_000;
	localparam int unsigned TIMEBASE_MS    = 1;
	localparam int unsigned CYCLES_PER_MS  = CLK_HZ / 1000 * TIMEBASE_MS;
	localparam int unsigned UNIT_10MS      = 10;

	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL        = 8'h00;
	localparam logic [7:0] OFS_SON_WAIT    = 8'h04;
	localparam logic [7:0] OFS_SOFF_WAIT   = 8'h08;
	localparam logic [7:0] OFS_BRK_SPEED   = 8'h0c;
	localparam logic [7:0] OFS_BRK_WAIT    = 8'h10;
	localparam logic [7:0] OFS_REV_TORQUE  = 8'h14;
	localparam logic [7:0] OFS_STATUS      = 8'h18;
	localparam logic [7:0] OFS_IRQ_STAT    = 8'h1c;
	localparam logic [7:0] OFS_IRQ_CLR     = 8'h20;
	localparam logic [7:0] OFS_IRQ_EN      = 8'h24;

	// Control register field positions.
	localparam int unsigned CTRL_SON_BIT   = 0;
	localparam int unsigned CTRL_STOP_LSB  = 4;
	localparam int unsigned CTRL_TERM_LSB  = 8;
	localparam int unsigned TERM_FIELD_W   = 4;
	localparam int unsigned NUM_TERMS      = 3;

	// Field codes.
	localparam logic [3:0] TERM_SEL_BRAKE  = 4'h4;
	localparam logic [2:0] STOP_REV_DB     = 3'h3;
	localparam logic [2:0] STOP_REV_COAST  = 3'h4;

	// Reset values and legal ranges.
	localparam logic signed [11:0] SON_WAIT_RST  = 12'sh000;
	localparam logic signed [11:0] SON_WAIT_MAX  = 12'sd2000;
	localparam logic signed [11:0] SON_WAIT_MIN  = -12'sd2000;
	localparam logic [8:0]  SOFF_WAIT_RST  = 9'h000;
	localparam logic [8:0]  SOFF_WAIT_MAX  = 9'd500;
	localparam logic [6:0]  BRK_SPEED_RST  = 7'd100;
	localparam logic [6:0]  BRK_WAIT_RST   = 7'd50;
	localparam logic [6:0]  BRK_RANGE_MIN  = 7'd10;
	localparam logic [6:0]  BRK_RANGE_MAX  = 7'd100;
	localparam logic [8:0]  REV_TORQUE_RST = 9'd300;
	localparam logic [8:0]  REV_TORQUE_MAX = 9'd350;

	// Interrupt bit positions.
	localparam int unsigned IRQ_READY      = 0;
	localparam int unsigned IRQ_BRAKE      = 1;
	localparam int unsigned IRQ_ALARM      = 2;
	localparam int unsigned IRQ_W          = 3;

	// Sequencer states.
	typedef enum logic [2:0] {
		ST_OFF, ST_ON_PWR, ST_ON_BRK, ST_RUN, ST_OFF_DLY, ST_DECEL, ST_COAST
	} hbs_state_e;

	// Avalon-MM request from the master.
	typedef struct packed {
		logic        read;
		logic        write;
		logic [7:0]  address;
		logic [31:0] writedata;
	} hbs_avm_req_s;

endpackage

//--- hbs_sync3.sv
`timescale 1ns/100ps
module hbs_sync3 (
	// Clock and reset.
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	// Asynchronous level in, filtered level out.
	input  wire logic async_i,
	output logic      level_o
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	// The level changes only once the second and third stages agree.
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			s1_q    <= 1'b0;
			s2_q    <= 1'b0;
			s3_q    <= 1'b0;
			level_o <= 1'b0;
		end else begin
			s1_q <= async_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level_o <= s3_q;
			end
		end
	end
endmodule // hbs_sync3
